// >>> rtl/irig_pkg.sv
package irig_pkg;

    // ==========================================
    // clock and timing
    localparam int CLK_PERIOD_NS  = 4;
    localparam int MS_NS          = 1000000;
    localparam int CYC_PER_MS     = MS_NS / CLK_PERIOD_NS;
    localparam int CARRIER_STEPS  = 16;
    localparam logic [3:0] ELEM_MS = 4'hA;
    localparam logic [3:0] ZERO_MS = 4'h2;
    localparam logic [3:0] ONE_MS  = 4'h5;
    localparam logic [3:0] MARK_MS = 4'h8;
    localparam logic [3:0] LAST_DIGIT = 4'h9;

    // ==========================================
    // frame field positions
    localparam int POS_SEC_U  = 1;
    localparam int POS_SEC_T  = 6;
    localparam int POS_MIN_U  = 10;
    localparam int POS_MIN_T  = 15;
    localparam int POS_HOUR_U = 20;
    localparam int POS_HOUR_T = 25;
    localparam int POS_DAY_U  = 30;
    localparam int POS_DAY_T  = 35;
    localparam int POS_DAY_H  = 40;
    localparam int FRAME_ELEMS = 100;

    // ==========================================
    // register map
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_POPW = 8'h04;
    localparam logic [7:0] OFS_STAT = 8'h08;
    localparam logic [7:0] OFS_EVT  = 8'h0C;
    localparam logic [7:0] OFS_MSG  = 8'h10;
    localparam logic [31:0] MSG_ANT_OFF = 32'h0000_0017;
    localparam logic [31:0] POPW_RESET  = 32'h0000_0000;
    localparam int ST_EVENT   = 0;
    localparam int ST_TC_EN   = 1;
    localparam int ST_VALID   = 2;
    localparam int ST_ALARM   = 3;
    localparam int ST_ANT_DIS = 4;

    // ==========================================
    // selector codes
    localparam logic [3:0] M1_PPS  = 4'h0;
    localparam logic [3:0] M1_F1K  = 4'h1;
    localparam logic [3:0] M1_F10M = 4'h6;
    localparam logic [3:0] M1_IRIG = 4'h7;
    localparam logic [3:0] M2_PPS  = 4'h0;
    localparam logic [3:0] M2_F10M = 4'h1;
    localparam logic [3:0] M2_MIRR = 4'h2;
    localparam logic [3:0] M2_IRIG = 4'h3;
    localparam logic [3:0] M2_OPT1 = 4'h4;
    localparam logic [3:0] M2_OPT5 = 4'h8;
    localparam logic [1:0] TC_FUNC_B = 2'h0;

    // ==========================================
    // carrier amplitudes, mark to space 3.3:1
    localparam logic [7:0] MOD_NUM = 8'h0A;
    localparam logic [7:0] MOD_DEN = 8'h21;

    typedef struct packed {
        logic [19:0] rsvd;
        logic [1:0]  tc_func;
        logic        pop_active_low;
        logic        event_falling;
        logic [3:0]  mux2_sel;
        logic [3:0]  mux1_sel;
    } ctrl_t;

    localparam ctrl_t CTRL_RESET = '0;

    typedef struct packed {
        logic [1:0] day_hund;
        logic [3:0] day_tens;
        logic [3:0] day_units;
        logic [1:0] hour_tens;
        logic [3:0] hour_units;
        logic [2:0] min_tens;
        logic [3:0] min_units;
        logic [2:0] sec_tens;
        logic [3:0] sec_units;
    } tc_time_t;

endpackage

// >>> rtl/irig_b_timecode_outputs.sv
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
module irig_b_timecode_outputs #(
    parameter int CYC_PER_MS = irig_pkg::CYC_PER_MS
) (
    // clock, reset, enable
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                ce,

    // apb slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,

    // timing sources
    input  wire logic                time_valid,
    input  wire logic                tc_option_present,
    input  wire logic                epoch_in,
    input  wire irig_pkg::tc_time_t  epoch_time,
    input  wire logic                pps_in,
    input  wire logic [5:0]          freq_in,
    input  wire logic [4:0]          opt_out_in,

    // event and alarms
    input  wire logic                event_in,
    input  wire logic                antenna_current_low,
    input  wire logic                fault_in,

    // non-volatile function store
    input  wire logic [1:0]          tc_func_restore,
    output logic      [1:0]          tc_func_store,

    // output pins
    output logic                     fault_indicator_out,
    output logic                     fault_indicator_oe,
    output logic                     pop_out,
    output logic                     first_selector_out_a,
    output logic                     second_selector_out,
    output logic                     baseband_code_out,
    output logic      [7:0]          modulated_code_pin,
    output logic                     modulated_code_en
);

    localparam int SUB_W  = $clog2(CYC_PER_MS);
    localparam int STEP_C = CYC_PER_MS / irig_pkg::CARRIER_STEPS;
    localparam int STEP_W = STEP_C > 1 ? $clog2(STEP_C) : 1;
    localparam logic [SUB_W-1:0]  SUB_LAST  = SUB_W'(CYC_PER_MS - 1);
    localparam logic [STEP_W-1:0] STEP_LAST = STEP_W'(STEP_C - 1);

    // ==========================================
    // functions
    // digits lsb first at their slots
    function automatic logic [99:0] build_frame(input irig_pkg::tc_time_t t);
        logic [99:0] f;
        f = '0;
        f[irig_pkg::POS_SEC_U  +: 4] = t.sec_units;
        f[irig_pkg::POS_SEC_T  +: 3] = t.sec_tens;
        f[irig_pkg::POS_MIN_U  +: 4] = t.min_units;
        f[irig_pkg::POS_MIN_T  +: 3] = t.min_tens;
        f[irig_pkg::POS_HOUR_U +: 4] = t.hour_units;
        f[irig_pkg::POS_HOUR_T +: 2] = t.hour_tens;
        f[irig_pkg::POS_DAY_U  +: 4] = t.day_units;
        f[irig_pkg::POS_DAY_T  +: 4] = t.day_tens;
        f[irig_pkg::POS_DAY_H  +: 2] = t.day_hund;
        return f;
    endfunction

    function automatic logic [7:0] carrier_sample(input logic [3:0] idx,
                                                  input logic       mark);
        logic [7:0]  mag;
        logic [15:0] scaled;
        mag = 8'h00;
        scaled = 16'h0000;
        case (idx[2:0])
            3'h0: mag = 8'h00;
            3'h1: mag = 8'h26;
            3'h2: mag = 8'h46;
            3'h3: mag = 8'h5B;
            3'h4: mag = 8'h63;
            3'h5: mag = 8'h5B;
            3'h6: mag = 8'h46;
            default: mag = 8'h26;
        endcase
        if (!mark) begin
            scaled = (16'(mag) * 16'(irig_pkg::MOD_NUM)) / 16'(irig_pkg::MOD_DEN);
            mag = scaled[7:0];
        end
        return idx[3] ? 8'(-mag) : mag;
    endfunction

    // ==========================================
    // state
    irig_pkg::ctrl_t    ctrl;
    irig_pkg::tc_time_t time_q;
    logic [31:0]        pop_width;
    logic [31:0]        pop_cnt;
    logic [31:0]        event_tag;
    logic               event_pending;
    logic               ant_rpt_dis;
    logic               restore_done;
    logic               tc_enabled;
    logic               running;
    logic               epoch_q;
    logic               event_q;

    logic [SUB_W-1:0]   sub;
    logic [STEP_W-1:0]  step;
    logic [3:0]         car_idx;
    logic [3:0]         ms;
    logic [3:0]         el_tens;
    logic [3:0]         el_units;
    logic [99:0]        frame;

    // ==========================================
    // apb decode
    wire access   = psel & penable;
    wire commit   = access & pready;
    wire hit_ctrl = paddr == irig_pkg::OFS_CTRL;
    wire hit_popw = paddr == irig_pkg::OFS_POPW;
    wire hit_stat = paddr == irig_pkg::OFS_STAT;
    wire hit_evt  = paddr == irig_pkg::OFS_EVT;
    wire hit_msg  = paddr == irig_pkg::OFS_MSG;

    wire mapped   = hit_ctrl | hit_popw | hit_stat | hit_evt | hit_msg;
    wire wr_ok    = commit & pwrite & mapped;

    // message 23 mutes only the antenna cause
    wire alarm = (antenna_current_low & ~ant_rpt_dis) | fault_in;

    wire [31:0] stat_val = {27'h0000000, ant_rpt_dis, alarm, time_valid,
                            tc_enabled, event_pending};

    wire [31:0] rd_val = hit_ctrl ? ctrl :
                         hit_popw ? pop_width :
                         hit_stat ? stat_val :
                         hit_evt  ? event_tag : 32'h0000_0000;

    // ==========================================
    // frame timing
    wire epoch_rise = epoch_in & ~epoch_q;
    wire ms_tick    = sub == SUB_LAST;
    wire step_tick  = step == STEP_LAST;
    wire elem_end   = ms_tick & (ms == irig_pkg::ELEM_MS - 4'h1);
    wire tens_last  = el_tens == irig_pkg::LAST_DIGIT;
    wire units_last = el_units == irig_pkg::LAST_DIGIT;
    wire frame_end  = elem_end & tens_last & units_last;

    wire restart    = epoch_rise & tc_enabled;
    wire is_marker  = units_last | (el_tens == 4'h0 && el_units == 4'h0);

    wire [3:0] width = is_marker ? irig_pkg::MARK_MS :
                       frame[0]  ? irig_pkg::ONE_MS : irig_pkg::ZERO_MS;

    wire tc_active = running & tc_enabled & (ctrl.tc_func == irig_pkg::TC_FUNC_B);
    wire next_baseband = tc_active & (ms < width);

    wire [7:0] next_mod = tc_active ? carrier_sample(car_idx, next_baseband)
                                    : 8'h00;

    // ==========================================
    // selectors
    wire [3:0] m2_opt = ctrl.mux2_sel - irig_pkg::M2_OPT1;

    wire mux1_raw =
        (ctrl.mux1_sel == irig_pkg::M1_PPS)  ? pps_in :
        (ctrl.mux1_sel == irig_pkg::M1_IRIG) ? next_baseband :
        (ctrl.mux1_sel >= irig_pkg::M1_F1K && ctrl.mux1_sel <= irig_pkg::M1_F10M)
            ? freq_in[3'(ctrl.mux1_sel - irig_pkg::M1_F1K)] : 1'b0;

    wire mux2_raw =
        (ctrl.mux2_sel == irig_pkg::M2_PPS)  ? pps_in :
        (ctrl.mux2_sel == irig_pkg::M2_F10M) ? freq_in[5] :
        (ctrl.mux2_sel == irig_pkg::M2_MIRR) ? mux1_raw :
        (ctrl.mux2_sel == irig_pkg::M2_IRIG) ? next_baseband :
        (ctrl.mux2_sel >= irig_pkg::M2_OPT1 && ctrl.mux2_sel <= irig_pkg::M2_OPT5)
            ? opt_out_in[3'(m2_opt)] : 1'b0;

    // ==========================================
    // event and pulse
    wire ev_rise = event_in & ~event_q;
    wire ev_fall = ~event_in & event_q;
    wire event_hit = time_valid & (ctrl.event_falling ? ev_fall : ev_rise);
    wire ev_clear = wr_ok & hit_stat & pwdata[irig_pkg::ST_EVENT];
    wire next_event_pending = event_hit | (event_pending & ~ev_clear);

    wire next_pop = (time_valid & (pop_cnt != 32'h0000_0000))
                    ^ ctrl.pop_active_low;

    // ==========================================
    // register file
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl          <= irig_pkg::CTRL_RESET;
            pop_width     <= irig_pkg::POPW_RESET;
            ant_rpt_dis   <= 1'b0;
            event_pending <= 1'b0;
            event_tag     <= 32'h0000_0000;
            restore_done  <= 1'b0;
        end else if (ce) begin
            // restore beats a same-cycle write
            if (!restore_done) begin
                ctrl.tc_func <= tc_func_restore;
                restore_done <= 1'b1;
            end else if (wr_ok && hit_ctrl) begin
                ctrl <= irig_pkg::ctrl_t'({20'h00000, pwdata[11:0]});
            end
            if (wr_ok && hit_popw) begin
                pop_width <= pwdata;
            end
            if (wr_ok && hit_msg && pwdata == irig_pkg::MSG_ANT_OFF) begin
                ant_rpt_dis <= 1'b1;
            end

            event_pending <= next_event_pending;
            if (event_hit) begin
                event_tag <= {el_tens, el_units, ms, 20'(sub)};
            end
        end
    end

    // ==========================================
    // apb answer, one wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready <= access & ~pready;
            if (access && !pready) begin
                prdata  <= pwrite ? 32'h0000_0000 : rd_val;
                pslverr <= ~mapped;
            end
        end
    end

    // ==========================================
    // enable and edge history
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tc_enabled <= 1'b0;
            epoch_q    <= 1'b0;
            event_q    <= 1'b0;
        end else if (ce) begin
            epoch_q <= epoch_in;
            event_q <= event_in;
            // sticky: code keeps running in coast
            if (time_valid && tc_option_present) begin
                tc_enabled <= 1'b1;
            end
        end
    end

    // ==========================================
    // element and carrier counters
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            running  <= 1'b0;
            sub      <= '0;
            step     <= '0;
            car_idx  <= 4'h0;
            ms       <= 4'h0;
            el_tens  <= 4'h0;
            el_units <= 4'h0;
            frame    <= '0;
            time_q   <= '0;
        end else if (ce) begin
            if (restart) begin
                running  <= 1'b1;
                sub      <= '0;
                step     <= '0;
                car_idx  <= 4'h0;
                ms       <= 4'h0;
                el_tens  <= 4'h0;
                el_units <= 4'h0;
                time_q   <= epoch_time;
                frame    <= build_frame(epoch_time);
            end else if (running) begin
                sub  <= ms_tick ? '0 : sub + SUB_W'(1);
                step <= (step_tick || ms_tick) ? '0 : step + STEP_W'(1);
                if (ms_tick) begin
                    car_idx <= 4'h0;
                end else if (step_tick) begin
                    car_idx <= car_idx + 4'h1;
                end
                if (ms_tick) begin
                    ms <= elem_end ? 4'h0 : ms + 4'h1;
                end
                // no epoch: resend the last time
                if (frame_end) begin
                    el_tens  <= 4'h0;
                    el_units <= 4'h0;
                    frame    <= build_frame(time_q);
                end else if (elem_end) begin
                    frame    <= frame >> 1;
                    el_units <= units_last ? 4'h0 : el_units + 4'h1;
                    if (units_last) begin
                        el_tens <= el_tens + 4'h1;
                    end
                end
            end
        end
    end

    // ==========================================
    // programmed pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pop_cnt <= 32'h0000_0000;
        end else if (ce) begin
            if (epoch_rise && time_valid) begin
                pop_cnt <= pop_width;
            end else if (pop_cnt != 32'h0000_0000) begin
                pop_cnt <= pop_cnt - 32'h0000_0001;
            end
        end
    end

    // ==========================================
    // output pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_indicator_out  <= 1'b1;
            fault_indicator_oe   <= 1'b0;
            pop_out              <= 1'b0;
            first_selector_out_a <= 1'b0;
            second_selector_out  <= 1'b0;
            baseband_code_out    <= 1'b0;
            modulated_code_pin   <= 8'h00;
            modulated_code_en    <= 1'b0;
            tc_func_store        <= 2'h0;
        end else if (ce) begin
            fault_indicator_out  <= ~alarm;
            fault_indicator_oe   <= alarm;
            pop_out              <= next_pop;
            first_selector_out_a <= time_valid & mux1_raw;
            second_selector_out  <= time_valid & mux2_raw;
            baseband_code_out    <= next_baseband;
            modulated_code_pin   <= next_mod;
            modulated_code_en    <= tc_active;
            tc_func_store        <= ctrl.tc_func;
        end
    end

endmodule

// >>> dv/irig_b_timecode_outputs_monitor.sv
`timescale 1ns/10ps
module irig_b_timecode_outputs_monitor #(
    parameter int CYC_PER_MS = 16
) (
    // clock and qualifiers
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       ce,
    input wire logic       time_valid,
    input wire logic       tc_option_present,
    input wire logic       epoch_in,
    input wire logic       fault_in,
    // observed outputs
    input wire logic       fault_indicator_out,
    input wire logic       fault_indicator_oe,
    input wire logic       first_selector_out_a,
    input wire logic       second_selector_out,
    input wire logic       baseband_code_out,
    input wire logic [7:0] modulated_code_pin,
    input wire logic       modulated_code_en,
    input wire logic [1:0] tc_func_store
);
    logic        seen_valid;
    logic [31:0] hi_len;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // ==========================================
    // valid-time history and mark length
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seen_valid <= 1'b0;
            hi_len     <= 32'h0;
        end else if (ce) begin
            seen_valid <= seen_valid | (time_valid & tc_option_present);
            hi_len     <= baseband_code_out ? hi_len + 32'h1 : 32'h0;
        end
    end

    // ==========================================
    // assertions
    chk_fault_pair: assert property (fault_indicator_oe != fault_indicator_out)
        else $error("fault pin drive and enable disagree");
    chk_fault_follow: assert property (fault_in && ce |-> ##[1:3] fault_indicator_oe)
        else $error("alarm not shown on fault pin");
    chk_sel_gated: assert property (
        ce && !time_valid |=> !first_selector_out_a && !second_selector_out)
        else $error("selector active without valid time");
    chk_code_off: assert property (
        !seen_valid |-> !modulated_code_en && !baseband_code_out)
        else $error("time code active before valid time");
    chk_code_stays: assert property (modulated_code_en |=> modulated_code_en)
        else $error("time code output dropped");
    chk_epoch_start: assert property (
        $rose(epoch_in) && ce && seen_valid && tc_func_store == 2'h0
        |-> ##2 baseband_code_out && modulated_code_pin == 8'h00)
        else $error("reference marker not on epoch");
    chk_pulse_width: assert property ($fell(baseband_code_out) |->
        hi_len == 2 * CYC_PER_MS || hi_len == 5 * CYC_PER_MS || hi_len == 8 * CYC_PER_MS)
        else $error("element high time wrong");
    chk_space_amp: assert property (
        !baseband_code_out && !$past(baseband_code_out)
        |-> $signed(modulated_code_pin) <= 30 && $signed(modulated_code_pin) >= -30)
        else $error("space amplitude too large");

    cover property ($rose(baseband_code_out));
    cover property ($fell(fault_indicator_oe));
    cover property ($rose(modulated_code_en));
endmodule

// >>> dv/irig_code_receiver.sv
`timescale 1ns/10ps
module irig_code_receiver #(
    parameter int CYC_PER_MS = 16
) (
    // clock and control
    input  wire logic              pclk,
    input  wire logic              clr,
    // observed pins
    input  wire logic              code_in,
    input  wire logic signed [7:0] carrier_in,
    input  wire logic              fault_oe,
    input  wire logic              fault_drv,
    // resolved alarm line
    output logic                   fault_line
);
    logic [1:0]        sym [100];
    int                n;
    int                width;
    logic signed [7:0] mark_max;
    logic signed [7:0] space_max;

    // external pull-up on the open-collector line
    assign fault_line = fault_oe ? fault_drv : 1'b1;

    // ==========================================
    // width classifier and carrier peaks
    always @(posedge pclk) begin
        if (clr) begin
            n = 0;
            width = 0;
            mark_max = 8'sh00;
            space_max = 8'sh00;
        end else begin
            if (code_in) width++;
            else if (width != 0) begin
                if (n < 100) sym[n] = width == 2 * CYC_PER_MS ? 2'h0 :
                    width == 5 * CYC_PER_MS ? 2'h1 : width == 8 * CYC_PER_MS ? 2'h2 : 2'h3;
                n++;
                width = 0;
            end
            if (code_in && carrier_in > mark_max) mark_max = carrier_in;
            if (!code_in && carrier_in > space_max) space_max = carrier_in;
        end
    end
endmodule

// >>> dv/test_irig_b_timecode_outputs.sv
`timescale 1ns/10ps
module test_irig_b_timecode_outputs;
    typedef struct packed {
        logic [3:0] s1;
        logic [3:0] s2;
        logic [3:0] e;
    } row_t;

    logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, time_valid, pop_lvl;
    logic tc_option_present, epoch_in, pps_in, event_in, antenna_current_low, fault_in;
    logic fault_indicator_out, fault_indicator_oe, pop_out, first_selector_out_a;
    logic second_selector_out, baseband_code_out, modulated_code_en, clr, fault_line, er;
    logic [7:0]         paddr, modulated_code_pin;
    logic [31:0]        pwdata, prdata, rd;
    logic [5:0]         freq_in;
    logic [4:0]         opt_out_in;
    logic [1:0]         tc_func_restore, tc_func_store;
    logic [1:0]         exp_sym [100];
    irig_pkg::tc_time_t epoch_time;
    int                 n_mismatch, num_checks, pop_cnt, base;
    row_t               rows [9] = '{12'h003, 12'h112, 12'h220, 12'h343, 12'h451, 12'h562,
                                     12'h671, 12'h582, 12'h523};

    irig_b_timecode_outputs #(.CYC_PER_MS(16)) DUT (
        .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .time_valid, .tc_option_present, .epoch_in, .epoch_time, .pps_in,
        .freq_in, .opt_out_in, .event_in, .antenna_current_low, .fault_in, .tc_func_restore,
        .tc_func_store, .fault_indicator_out, .fault_indicator_oe, .pop_out,
        .first_selector_out_a, .second_selector_out, .baseband_code_out,
        .modulated_code_pin, .modulated_code_en);
    irig_code_receiver #(.CYC_PER_MS(16)) rx (.pclk, .clr, .code_in(baseband_code_out),
        .carrier_in(modulated_code_pin), .fault_oe(fault_indicator_oe),
        .fault_drv(fault_indicator_out), .fault_line);

    // ==========================================
    // helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic do_reset(input logic [1:0] rs);
        @(posedge pclk);
        presetn <= 1'b0;
        tc_func_restore <= rs;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
    endtask
    task automatic pulse_epoch;
        @(posedge pclk);
        epoch_in <= 1'b1;
        repeat (4) @(posedge pclk);
        epoch_in <= 1'b0;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic put(input int pos, input logic [3:0] v, input int nb);
        for (int k = 0; k < nb; k++) exp_sym[pos + k] = {1'b0, v[k]};
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    initial begin
        #100000;
        n_mismatch++;
        conclude();
    end
    always @(negedge pclk) if (pop_out === pop_lvl) pop_cnt++;

    // ==========================================
    // test sequence
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, time_valid, tc_option_present} = '0;
        {epoch_in, epoch_time, event_in, antenna_current_low, fault_in} = '0;
        {ce, pps_in, clr, pop_lvl} = 4'hF;
        freq_in = 6'h15;
        opt_out_in = 5'h0B;
        tc_func_restore = 2'h1;
        do_reset(2'h1);
        chk(tc_func_store, 2'h1);
        apb(1'b0, irig_pkg::OFS_CTRL, 32'h0);
        chk(rd, 32'h0000_0400);
        time_valid <= 1'b1;
        tc_option_present <= 1'b1;
        pulse_epoch();
        step(20);
        chk(modulated_code_en, 1'b0);
        $display("test restore finished");
        time_valid <= 1'b0;
        tc_option_present <= 1'b0;
        do_reset(2'h0);
        apb(1'b0, irig_pkg::OFS_CTRL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h14, 32'h0);
        chk({er, rd[30:0]}, 32'h8000_0000);
        apb(1'b1, irig_pkg::OFS_POPW, 32'h5);
        base = pop_cnt;
        pulse_epoch();
        event_in <= 1'b1;
        step(10);
        chk(pop_cnt - base, 0);
        chk(second_selector_out, 1'b0);
        apb(1'b0, irig_pkg::OFS_STAT, 32'h0);
        chk(rd[0], 1'b0);
        event_in <= 1'b0;
        time_valid <= 1'b1;
        foreach (rows[i]) begin
            apb(1'b1, irig_pkg::OFS_CTRL, {24'h0, rows[i].s2, rows[i].s1});
            step(3);
            chk({first_selector_out_a, second_selector_out}, rows[i].e[1:0]);
        end
        $display("test selectors finished");
        fault_in <= 1'b1;
        step(4);
        chk(fault_line, 1'b0);
        fault_in <= 1'b0;
        antenna_current_low <= 1'b1;
        step(4);
        chk(fault_line, 1'b0);
        apb(1'b1, irig_pkg::OFS_MSG, irig_pkg::MSG_ANT_OFF);
        step(4);
        chk(fault_line, 1'b1);
        apb(1'b0, irig_pkg::OFS_STAT, 32'h0);
        chk(rd[4], 1'b1);
        $display("test alarm finished");
        apb(1'b1, irig_pkg::OFS_CTRL, 32'h0);
        event_in <= 1'b1;
        step(3);
        apb(1'b0, irig_pkg::OFS_STAT, 32'h0);
        chk(rd[0], 1'b1);
        apb(1'b1, irig_pkg::OFS_STAT, 32'h1);
        event_in <= 1'b0;
        step(3);
        apb(1'b0, irig_pkg::OFS_STAT, 32'h0);
        chk(rd[0], 1'b0);
        apb(1'b1, irig_pkg::OFS_CTRL, 32'h100);
        event_in <= 1'b1;
        step(3);
        apb(1'b0, irig_pkg::OFS_STAT, 32'h0);
        chk(rd[0], 1'b0);
        event_in <= 1'b0;
        step(3);
        apb(1'b0, irig_pkg::OFS_STAT, 32'h0);
        chk(rd[0], 1'b1);
        $display("test event finished");
        for (int p = 0; p < 2; p++) begin
            apb(1'b1, irig_pkg::OFS_CTRL, p ? 32'h200 : 32'h0);
            step(2);
            pop_lvl = !p;
            base = pop_cnt;
            pulse_epoch();
            step(10);
            chk(pop_cnt - base, 5);
        end
        $display("test pulse finished");
        exp_sym = '{default: 2'h0};
        for (int k = 0; k < 100; k += 10) exp_sym[k ? k - 1 : 0] = 2'h2;
        exp_sym[99] = 2'h2;
        put(1, 4'h9, 4);
        put(6, 4'h3, 3);
        put(10, 4'h5, 4);
        put(15, 4'h4, 3);
        put(20, 4'h7, 4);
        put(25, 4'h1, 2);
        put(30, 4'h3, 4);
        put(35, 4'h6, 4);
        put(40, 4'h2, 2);
        apb(1'b1, irig_pkg::OFS_CTRL, 32'h0000_0037);
        epoch_time <= {2'h2, 4'h6, 4'h3, 2'h1, 4'h7, 3'h4, 4'h5, 3'h3, 4'h9};
        tc_option_present <= 1'b1;
        clr <= 1'b0;
        pulse_epoch();
        step(55);
        chk({first_selector_out_a, second_selector_out}, 2'h3);
        chk(modulated_code_en, 1'b1);
        step(100);
        chk({first_selector_out_a, second_selector_out}, 2'h0);
        step(15835);
        chk(rx.n, 100);
        time_valid <= 1'b0;
        pulse_epoch();
        step(20);
        chk(modulated_code_en, 1'b1);
        for (int i = 0; i < 100; i++) chk(rx.sym[i], exp_sym[i]);
        chk({rx.mark_max, rx.space_max}, 16'h631E);
        $display("test frame finished");
        conclude();
    end
endmodule

bind irig_b_timecode_outputs irig_b_timecode_outputs_monitor #(.CYC_PER_MS(CYC_PER_MS)) u_mon (
    .pclk, .presetn, .ce, .time_valid, .tc_option_present, .epoch_in, .fault_in,
    .fault_indicator_out, .fault_indicator_oe, .first_selector_out_a, .second_selector_out,
    .baseband_code_out, .modulated_code_pin, .modulated_code_en, .tc_func_store);
